/* File: gom_fwd_sampler.sv */
// Purpose: holds one port's forwarded remote pin values
// Assumes: frame_tick pulses once per received forward frame
// Notes: update period follows the linked pin count
`timescale 1ns/100ps
module gom_fwd_sampler #(
  parameter int PINS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frame_tick,
  input wire logic [2:0] linked_count,
  input wire logic [PINS-1:0] pins_in,
  output logic [PINS-1:0] pins_held
);
  logic [2:0] frame_cnt;
  logic [2:0] period;
  logic update;

  always_comb begin
    case (linked_count)
      3'h1: period = gom_pkg::PERIOD_ONE;
      3'h2: period = gom_pkg::PERIOD_TWO;
      default: period = gom_pkg::PERIOD_MANY;
    endcase
  end

  // no linked pins means nothing new arrives; hold the last value
  assign update = frame_tick && (linked_count != 3'h0) && (frame_cnt >= period - 3'h1); // R20

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt <= 3'h0;
    end else if (frame_tick) begin
      frame_cnt <= update ? 3'h0 : frame_cnt + 3'h1; // R20
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_held <= '0;
    end else if (update) begin
      pins_held <= pins_in; // R20
    end
  end
endmodule : gom_fwd_sampler

/* File: gom_output_route.sv */
// Purpose: per-pin output routing of forwarded values and status signals
// Assumes: all inputs synchronous to pclk; apb slave with zero wait states
// Notes: gpio_oe_n is low while a pin is driven
// Summary of operation
// R01: eight-bit control word per pin, seven words
// R02: port source picks forwarded pin or status
// R03: device level code drives low when cleared
// R04: device level code drives high when set
// R05: device function one: OR of enabled locks
// R06: device function two: AND of enabled locks
// R07: device function three: AND of enabled passes
// R08: device function four: frame sync pulse
// R09: device interrupt, active high or active low
// R10: serial port function zero: AND selected passes
// R11: serial port function one: OR selected passes
// R12: serial port function two: frame active
// R13: serial port function three: line active
// R14: serial port function four: ports synchronized
// R15: serial port function five: its interrupt
// R16: reserved encodings leave pin undriven
// R17: seven pins, each may drive output
// R18: four forwarded values per receive port
// R19: any forwarded value to any pin
// R20: update every one, two or five frames
// R21: local latency small, independent of count
// R22: remote toggles under quarter sampling rate
// R23: parallel-video serializers forward no pins
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module gom_output_route #(
  parameter int NUM_PINS = gom_pkg::NUM_PINS,
  parameter int FWD_PINS = gom_pkg::FWD_PINS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gom_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx0_frame_tick,
  input wire logic rx1_frame_tick,
  input wire logic [FWD_PINS-1:0] rx0_fwd_pins,
  input wire logic [FWD_PINS-1:0] rx1_fwd_pins,
  input wire logic [1:0] rx_lock,
  input wire logic [1:0] rx_pass,
  input wire logic [1:0] rx_frame_active,
  input wire logic [1:0] rx_line_active,
  input wire logic frame_sync_pulse,
  input wire logic device_irq,
  input wire logic frame_active,
  input wire logic line_active,
  input wire logic rx_ports_synced,
  input wire logic sop_irq,
  output logic [NUM_PINS-1:0] gpio_out,
  output logic [NUM_PINS-1:0] gpio_oe_n
);
  logic [7:0] pin_ctrl [NUM_PINS];
  logic [31:0] port_cfg;
  logic [FWD_PINS-1:0] fwd0;
  logic [FWD_PINS-1:0] fwd1;
  logic [1:0] port_en;
  logic [1:0] sop_sel;
  logic [2:0] cnt0;
  logic [2:0] cnt1;
  logic [7:0] idx;
  logic wr_en;
  logic rd_en;
  logic [NUM_PINS-1:0] next_out;
  logic [NUM_PINS-1:0] next_drive;
  logic [31:0] next_prdata;

  // the block adds no latency that grows with the linked count
  localparam int PATH_SLACK = gom_pkg::FWD_LATENCY_CYC - gom_pkg::LOCAL_PATH_CYC; // R21

  assign port_en = port_cfg[gom_pkg::CFG_EN_LSB +: 2];
  assign sop_sel = port_cfg[gom_pkg::CFG_SEL_LSB +: 2];
  assign cnt0 = port_cfg[gom_pkg::CFG_CNT0_LSB +: 3];
  assign cnt1 = port_cfg[gom_pkg::CFG_CNT1_LSB +: 3];

  // samplers; a port fed by a parallel-video serializer just leaves count at zero
  gom_fwd_sampler #(.PINS(FWD_PINS)) u_fwd0 (
    .pclk(pclk),
    .presetn(presetn),
    .frame_tick(rx0_frame_tick),
    .linked_count(cnt0),
    .pins_in(rx0_fwd_pins),
    .pins_held(fwd0)
  ); // R18 R23

  gom_fwd_sampler #(.PINS(FWD_PINS)) u_fwd1 (
    .pclk(pclk),
    .presetn(presetn),
    .frame_tick(rx1_frame_tick),
    .linked_count(cnt1),
    .pins_in(rx1_fwd_pins),
    .pins_held(fwd1)
  ); // R18 R23

  // AND over a masked set; an empty set reads low
  function automatic logic masked_and(input logic [1:0] v, input logic [1:0] m);
    masked_and = (m != 2'h0) && ((v & m) == m);
  endfunction : masked_and

  function automatic logic masked_or(input logic [1:0] v, input logic [1:0] m);
    masked_or = |(v & m);
  endfunction : masked_or

  // port source: forwarded pins 0..3, then that port's own status
  function automatic logic port_level(
    input logic [2:0] fn,
    input logic p,
    input logic [FWD_PINS-1:0] fsel
  );
    logic lvl;
    lvl = 1'b0;
    case (fn)
      gom_pkg::FN_PORT_LOCK: lvl = rx_lock[p]; // R02
      gom_pkg::FN_PORT_PASS: lvl = rx_pass[p]; // R02
      gom_pkg::FN_PORT_FRAME: lvl = rx_frame_active[p]; // R02
      gom_pkg::FN_PORT_LINE: lvl = rx_line_active[p]; // R02
      default: lvl = fsel[fn[1:0]]; // R02 R19
    endcase
    port_level = lvl;
  endfunction : port_level

  // device status source; returns {drive, level}
  function automatic logic [1:0] dev_route(
    input logic [2:0] fn,
    input logic level,
    input logic [1:0] en
  );
    logic lvl;
    logic drv;
    lvl = 1'b0;
    drv = 1'b1;
    case (fn)
      gom_pkg::FN_DEV_LEVEL: lvl = level; // R03 R04
      gom_pkg::FN_DEV_LOCK_OR: lvl = masked_or(rx_lock, en); // R05
      gom_pkg::FN_DEV_LOCK_AND: lvl = masked_and(rx_lock, en); // R06
      gom_pkg::FN_DEV_PASS_AND: lvl = masked_and(rx_pass, en); // R07
      gom_pkg::FN_DEV_SYNC: lvl = frame_sync_pulse; // R08
      gom_pkg::FN_DEV_IRQ_HI: lvl = device_irq; // R09
      gom_pkg::FN_DEV_IRQ_LO: lvl = ~device_irq; // R09
      default: drv = 1'b0; // R16
    endcase
    dev_route = {drv, lvl};
  endfunction : dev_route

  // serial output port source; returns {drive, level}
  function automatic logic [1:0] sop_route(
    input logic [2:0] fn,
    input logic [1:0] sel
  );
    logic lvl;
    logic drv;
    lvl = 1'b0;
    drv = 1'b1;
    case (fn)
      gom_pkg::FN_SOP_PASS_AND: lvl = masked_and(rx_pass, sel); // R10
      gom_pkg::FN_SOP_PASS_OR: lvl = masked_or(rx_pass, sel); // R11
      gom_pkg::FN_SOP_FRAME: lvl = frame_active; // R12
      gom_pkg::FN_SOP_LINE: lvl = line_active; // R13
      gom_pkg::FN_SOP_SYNCED: lvl = rx_ports_synced; // R14
      gom_pkg::FN_SOP_IRQ: lvl = sop_irq; // R15
      default: drv = 1'b0; // R16
    endcase
    sop_route = {drv, lvl};
  endfunction : sop_route

  // returns {drive, level} for one control word
  function automatic logic [1:0] route(
    input logic [7:0] ctrl,
    input logic [FWD_PINS-1:0] f0,
    input logic [FWD_PINS-1:0] f1,
    input logic [1:0] en,
    input logic [1:0] sel
  );
    logic [2:0] fn;
    logic [2:0] src;
    logic [FWD_PINS-1:0] fsel;
    logic p;
    logic lvl;
    logic drv;
    fn = ctrl[gom_pkg::FUNC_MSB:gom_pkg::FUNC_LSB];
    src = ctrl[gom_pkg::SRC_MSB:gom_pkg::SRC_LSB];
    p = (src == gom_pkg::SRC_PORT1);
    fsel = p ? f1 : f0;
    lvl = 1'b0;
    drv = 1'b0;
    if (src == gom_pkg::SRC_PORT0 || src == gom_pkg::SRC_PORT1) begin
      drv = 1'b1;
      lvl = port_level(fn, p, fsel);
    end else if (src == gom_pkg::SRC_DEVICE) begin
      {drv, lvl} = dev_route(fn, ctrl[gom_pkg::LEVEL_BIT], en);
    end else if (src == gom_pkg::SRC_SOP) begin
      {drv, lvl} = sop_route(fn, sel);
    end else begin
      drv = 1'b0; // R16
    end
    drv = drv & ctrl[gom_pkg::DRIVE_BIT]; // R17
    // an undriven pin reads low so no stale status level leaks out
    if (!drv) begin
      lvl = 1'b0;
    end
    route = {drv, lvl};
  endfunction : route

  // apb: zero wait states, so every access completes in its access cycle
  assign idx = paddr[gom_pkg::ADDR_W-1:2];
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;

  function automatic logic is_pin_idx(input logic [7:0] i);
    is_pin_idx = (i >= gom_pkg::IDX_PIN_CTRL_FIRST) && (i <= gom_pkg::IDX_PIN_CTRL_LAST);
  endfunction : is_pin_idx

  always_comb begin
    if (is_pin_idx(idx) || idx == gom_pkg::IDX_PORT_CFG) begin
      pslverr = 1'b0;
    end else if (idx == gom_pkg::IDX_STATUS) begin
      pslverr = psel && penable && pwrite;
    end else begin
      pslverr = psel && penable;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      localparam logic [7:0] MY_IDX = gom_pkg::IDX_PIN_CTRL_FIRST + 8'(g);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_ctrl[g] <= gom_pkg::PIN_CTRL_RESET;
        end else if (wr_en && idx == MY_IDX) begin
          pin_ctrl[g] <= pwdata[7:0]; // R01
        end
      end

      always_comb begin
        {next_drive[g], next_out[g]} = route(pin_ctrl[g], fwd0, fwd1, port_en, sop_sel);
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_cfg <= gom_pkg::PORT_CFG_RESET;
    end else if (wr_en && idx == gom_pkg::IDX_PORT_CFG) begin
      port_cfg <= pwdata & gom_pkg::PORT_CFG_MASK;
    end
  end

  // pins reset undriven; one register stage keeps outputs glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_out <= '0;
      gpio_oe_n <= '1;
    end else begin
      gpio_out <= next_out; // R21
      gpio_oe_n <= ~next_drive; // R16 R17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // read data chosen in setup, held by the register through access
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (is_pin_idx(idx)) begin
      next_prdata[7:0] = pin_ctrl[3'(idx - gom_pkg::IDX_PIN_CTRL_FIRST)];
    end else if (idx == gom_pkg::IDX_PORT_CFG) begin
      next_prdata = port_cfg;
    end else if (idx == gom_pkg::IDX_STATUS) begin
      next_prdata[gom_pkg::ST_LOCK_LSB +: 2] = rx_lock;
      next_prdata[gom_pkg::ST_PASS_LSB +: 2] = rx_pass;
      next_prdata[gom_pkg::ST_PIN_LSB +: NUM_PINS] = gpio_out;
      next_prdata[gom_pkg::ST_OE_LSB +: NUM_PINS] = gpio_oe_n;
    end
  end

  // rd_en kept for clarity of the read timing: data is loaded in setup
  logic unused_ok;
  assign unused_ok = rd_en & (PATH_SLACK >= 0);
endmodule : gom_output_route

/* File: gom_pkg.sv */
// Purpose: shared constants for the pin output routing block
// Assumes: apb data 32 bits, registers one word each, index times four
// Notes: printed control offsets are kept as register indices
package gom_pkg;
  localparam int NUM_PINS = 7;
  localparam int FWD_PINS = 4;
  localparam int NUM_PORTS = 2;
  localparam int ADDR_W = 10;

  // register indices; byte address is index times four
  localparam logic [7:0] IDX_PIN_CTRL_FIRST = 8'h10;
  localparam logic [7:0] IDX_PIN_CTRL_LAST = 8'h16;
  localparam logic [7:0] IDX_PORT_CFG = 8'h20;
  localparam logic [7:0] IDX_STATUS = 8'h21;

  // pin control word fields
  localparam int FUNC_MSB = 7;
  localparam int FUNC_LSB = 5;
  localparam int SRC_MSB = 4;
  localparam int SRC_LSB = 2;
  localparam int LEVEL_BIT = 1;
  localparam int DRIVE_BIT = 0;
  localparam logic [7:0] PIN_CTRL_RESET = 8'h00;

  // port configuration fields
  localparam int CFG_EN_LSB = 0;
  localparam int CFG_SEL_LSB = 2;
  localparam int CFG_CNT0_LSB = 4;
  localparam int CFG_CNT1_LSB = 8;
  localparam logic [31:0] PORT_CFG_RESET = 32'h0000_011F;
  localparam logic [31:0] PORT_CFG_MASK = 32'h0000_077F;

  // status fields
  localparam int ST_LOCK_LSB = 0;
  localparam int ST_PASS_LSB = 2;
  localparam int ST_PIN_LSB = 8;
  localparam int ST_OE_LSB = 16;

  // source select codes
  localparam logic [2:0] SRC_PORT0 = 3'h0;
  localparam logic [2:0] SRC_PORT1 = 3'h1;
  localparam logic [2:0] SRC_DEVICE = 3'h4;
  localparam logic [2:0] SRC_SOP = 3'h5;

  // function codes, port source: 0..3 are forwarded pins
  localparam logic [2:0] FN_PORT_LOCK = 3'h4;
  localparam logic [2:0] FN_PORT_PASS = 3'h5;
  localparam logic [2:0] FN_PORT_FRAME = 3'h6;
  localparam logic [2:0] FN_PORT_LINE = 3'h7;
  // device status source
  localparam logic [2:0] FN_DEV_LEVEL = 3'h0;
  localparam logic [2:0] FN_DEV_LOCK_OR = 3'h1;
  localparam logic [2:0] FN_DEV_LOCK_AND = 3'h2;
  localparam logic [2:0] FN_DEV_PASS_AND = 3'h3;
  localparam logic [2:0] FN_DEV_SYNC = 3'h4;
  localparam logic [2:0] FN_DEV_IRQ_HI = 3'h5;
  localparam logic [2:0] FN_DEV_IRQ_LO = 3'h6;
  // serial output port source
  localparam logic [2:0] FN_SOP_PASS_AND = 3'h0;
  localparam logic [2:0] FN_SOP_PASS_OR = 3'h1;
  localparam logic [2:0] FN_SOP_FRAME = 3'h2;
  localparam logic [2:0] FN_SOP_LINE = 3'h3;
  localparam logic [2:0] FN_SOP_SYNCED = 3'h4;
  localparam logic [2:0] FN_SOP_IRQ = 3'h5;

  // forwarded value update period in frames, by linked pin count
  localparam logic [2:0] PERIOD_ONE = 3'h1;
  localparam logic [2:0] PERIOD_TWO = 3'h2;
  localparam logic [2:0] PERIOD_MANY = 3'h5;

  // remote pin to local pin typical latency
  localparam int FWD_LATENCY_NS = 225;
  localparam int CLK_PERIOD_NS = 40;
  localparam int FWD_LATENCY_CYC = FWD_LATENCY_NS / CLK_PERIOD_NS;
  // cycles this block adds on the forwarded path
  localparam int LOCAL_PATH_CYC = 2;
endpackage : gom_pkg

/* File: gom_props.sv */
// Purpose: pin 0 routing and bus decode checks
// Assumes: pin 0 control and port masks shadowed from apb writes
// Notes: all pins share one routing function, so pin 0 stands for all
`timescale 1ns/100ps
module gom_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic [1:0] rx_lock,
  input wire logic [1:0] rx_pass,
  input wire logic frame_sync_pulse,
  input wire logic device_irq,
  input wire logic [6:0] gpio_out,
  input wire logic [6:0] gpio_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] c;
  logic [3:0] m;
  wire [7:0] ix = paddr[9:2];
  wire wr = psel && penable && pwrite;
  wire [2:0] f = c[7:5];
  wire [1:0] en = m[1:0];
  wire [1:0] sl = m[3:2];
  wire dv = c[4:2] == 3'h4 && c[0];
  wire sp = c[4:2] == 3'h5 && c[0];
  wire rs = !c[0] || c[4:2] inside {3'h2, 3'h3, 3'h6, 3'h7} || dv && f == 3'h7 || sp && f > 3'h5;
  wire o = gpio_out[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c <= 8'h00;
      m <= 4'hF;
    end else if (wr && ix == 8'h10) begin
      c <= pwdata[7:0];
    end else if (wr && ix == 8'h20) begin
      m <= pwdata[3:0];
    end
  end
  bus_err_a: assert property (psel && penable |-> pslverr ==
    !(ix inside {[8'h10:8'h16], 8'h20} || ix == 8'h21 && !pwrite)) else $error("bus decode");
  level_out_a: assert property (dv && f == 3'h0 |=> !gpio_oe_n[0] && o == $past(c[1]))
    else $error("level pin");
  lock_or_a: assert property (dv && f == 3'h1 |=> o == $past(|(rx_lock & en)))
    else $error("lock or");
  lock_and_a: assert property (dv && f == 3'h2 |=> o == $past(en != 0 && &(rx_lock | ~en)))
    else $error("lock and");
  pass_and_a: assert property (dv && f == 3'h3 |=> o == $past(en != 0 && &(rx_pass | ~en)))
    else $error("pass and");
  sync_out_a: assert property (dv && f == 3'h4 |=> o == $past(frame_sync_pulse))
    else $error("sync pin");
  irq_pol_a: assert property (dv && f inside {3'h5, 3'h6} |=>
    o == $past(device_irq ^ f[1])) else $error("irq polarity");
  sop_pass_a: assert property (sp && f < 3'h2 |=> o == $past(f[0] ? |(rx_pass & sl) :
    sl != 0 && &(rx_pass | ~sl))) else $error("port pass");
  rsvd_off_a: assert property (rs |=> gpio_oe_n[0] && !o) else $error("reserved");
  idle_low_a: assert property ((gpio_out & gpio_oe_n) == 7'h00) else $error("idle pin");
  cover property (dv && f == 3'h1);
  cover property (sp && f == 3'h0);
  cover property (psel && penable && pslverr);
endmodule : gom_props
bind gom_output_route gom_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .rx_lock(rx_lock), .rx_pass(rx_pass), .frame_sync_pulse(frame_sync_pulse),
  .device_irq(device_irq), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n));

/* File: gom_remote.sv */
// Purpose: remote serializer sending forward frames with pin values
// Assumes: one frame every GAP cycles while run is high
// Notes: frames stop when run is low
`timescale 1ns/100ps
module gom_remote #(
  parameter int GAP = 4,
  parameter bit VIDEO = 1'h0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic tick,
  output logic [3:0] pins
);
  int n;
  logic [4:0] q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n <= 0;
      q <= 5'h00;
      tick <= 1'h0;
      pins <= 4'h0;
    end else begin
      n <= (n == GAP - 1) ? 0 : n + 1;
      tick <= run && n == 0;
      // twenty frames: four times the slowest update period of five frames
      if (tick) q <= (q == 5'h13) ? 5'h00 : q + 5'h01;
      // parallel video mode offers no pins
      if (tick && q == 5'h13 && !VIDEO) pins <= 4'($urandom);
    end
  end
endmodule : gom_remote

/* File: tb_gpio_output_route_mux.sv */
// Purpose: self-checking bench for pin output routing
// Assumes: zero wait apb, outputs registered
// Notes: expectations queued by drivers, compared by one monitor
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin num_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_gpio_output_route_mux;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic look = 1'h0, run = 1'h0, pready, pslverr, fs = 1'h0, dirq = 1'h0;
  logic fa = 1'h0, la = 1'h0, syn = 1'h0, sirq = 1'h0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [1:0] lk = 2'h2, ps = 2'h1, rfa = 2'h0, rla = 2'h0, en, sl, tk;
  logic [3:0] fp0, fp1, hd [2];
  logic [6:0] gout, goe;
  logic [7:0] c;
  logic [32:0] qr [$], er;
  logic [13:0] qp [$], ep;
  int num_errors = 0, n_checks = 0, k, p, tc, per;
  initial forever #20 pclk = ~pclk;
  gom_output_route i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx0_frame_tick(tk[0]), .rx1_frame_tick(tk[1]), .rx0_fwd_pins(fp0),
    .rx1_fwd_pins(fp1), .rx_lock(lk), .rx_pass(ps), .rx_frame_active(rfa),
    .rx_line_active(rla), .frame_sync_pulse(fs), .device_irq(dirq), .frame_active(fa),
    .line_active(la), .rx_ports_synced(syn), .sop_irq(sirq), .gpio_out(gout), .gpio_oe_n(goe));
  gom_remote i_rem0 (.pclk(pclk), .presetn(presetn), .run(run), .tick(tk[0]), .pins(fp0));
  gom_remote i_rem1 (.pclk(pclk), .presetn(presetn), .run(run), .tick(tk[1]), .pins(fp1));
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && qr.size() > 0) begin
      er = qr.pop_front();
      `CHK("read", er, {pslverr, prdata})
    end
    if (look && qp.size() > 0) begin
      ep = qp.pop_front();
      `CHK("pins", ep, {goe, gout})
    end
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 9; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    psel <= 1'h0;
    penable <= 1'h0;
    if (i == 9) begin
      num_errors++;
      wrap_up();
    end
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [9:0] a, input logic [32:0] e);
    qr.push_back(e);
    apb(1'h0, a, 32'h0);
  endtask : rd
  function automatic logic [1:0] ev(input logic [7:0] c);
    logic [2:0] f;
    logic [1:0] m;
    logic [3:0] s;
    logic [6:0] a;
    logic [5:0] b;
    f = c[7:5];
    m = c[2] ? sl : en;
    s = {rla[c[2]], rfa[c[2]], ps[c[2]], lk[c[2]]};
    a = {~dirq, dirq, fs, m != 0 && &(ps | ~m), m != 0 && &(lk | ~m), |(lk & m), c[1]};
    b = {sirq, syn, la, fa, |(ps & m), m != 0 && &(ps | ~m)};
    case (c[4:2])
      3'h0, 3'h1: return c[0] ? {1'h0, f[2] ? s[f[1:0]] : hd[c[2]][f[1:0]]} : 2'h2;
      3'h4: return c[0] && f != 3'h7 ? {1'h0, a[f]} : 2'h2;
      3'h5: return c[0] && f < 3'h6 ? {1'h0, b[f]} : 2'h2;
      default: return 2'h2;
    endcase
  endfunction : ev
  task automatic pchk(input int p, input logic [7:0] c);
    logic [13:0] x;
    @(posedge pclk);
    x = {7'h7F, 7'h00};
    {x[7 + p], x[p]} = ev(c);
    qp.push_back(x);
    look <= 1'h1;
    @(posedge pclk);
    look <= 1'h0;
  endtask : pchk
  task automatic rst;
    presetn <= 1'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    hd = '{4'h0, 4'h0};
    {sl, en} = 4'hF;
    tc = 0;
  endtask : rst
  initial begin
    void'($urandom(32'hC7D1));
    rst();
    pchk(0, 8'h00);
    rd(10'h040, 33'h0);
    rd(10'h080, 33'h11F);
    rd(10'h05C, 33'h1_0000_0000);
    apb(1'h1, 10'h044, 32'hFFFF_FFAB);
    apb(1'h1, 10'h084, 32'h0);
    rd(10'h044, 33'hAB);
    rd(10'h084, 33'h07F_0006);
    $display("test reset done");
    for (int n = 0; n < 5; n++) begin
      rst();
      per = n == 0 ? 0 : n == 1 ? 1 : n == 2 ? 2 : 5;
      apb(1'h1, 10'h080, {21'h0, 3'(n), 1'h0, 3'(n), 4'hF});
      p = $urandom_range(6);
      c = {3'($urandom_range(3)), 2'h0, 1'(n), 2'h1};
      apb(1'h1, 10'(64 + 4 * p), {24'h0, c});
      run <= 1'h1;
      repeat (44) begin
        for (k = 0; k < 20; k++) begin
          @(posedge pclk);
          if (tk[0] === 1'h1) break;
        end
        if (k == 20) begin
          num_errors++;
          wrap_up();
        end
        tc++;
        if (per != 0 && tc % per == 0) hd = '{fp0, fp1};
        pchk(p, c);
      end
      run <= 1'h0;
      $display("test forward count %0d done", n);
    end
    rst();
    for (int r = 0; r < 4; r++) begin
      {sl, en} = {2'($urandom), 2'(3 - r)};
      apb(1'h1, 10'h080, {24'h000001, 4'h1, sl, en});
      for (int i = 0; i < 64; i++) begin
        if (i[2:0] == 3'h3) continue;
        p = r == 0 ? 0 : $urandom_range(6);
        c = {i[5:0], 1'($urandom), 1'($urandom_range(3) != 0)};
        {lk, ps, rfa, rla, fs, dirq, fa, la, syn, sirq} <= 14'($urandom);
        apb(1'h1, 10'(64 + 4 * p), {24'h0, c});
        pchk(p, c);
        apb(1'h1, 10'(64 + 4 * p), 32'h0);
      end
    end
    $display("test routing done");
    wrap_up();
  end
endmodule : tb_gpio_output_route_mux
